// ==== hw/tcs_consts.svh ====
`ifndef TCS_CONSTS_SVH
`define TCS_CONSTS_SVH
// byte addresses on the register bus
`define TCS_ADDR_COMBINED 8'h08
`define TCS_ADDR_CNT_HI 8'h09
`define TCS_ADDR_CNT_LO 8'h0A
`define TCS_ADDR_CMP1_HI 8'h0B
`define TCS_ADDR_CMP1_LO 8'h0C
`define TCS_ADDR_CAP1_HI 8'h0D
`define TCS_ADDR_CAP1_LO 8'h0E
`define TCS_ADDR_PIN_CTRL 8'h17
`define TCS_ADDR_IRQ_EN 8'h18
`define TCS_ADDR_STATUS 8'h19
`define TCS_ADDR_CMP2_HI 8'h1A
`define TCS_ADDR_CMP2_LO 8'h1B
`define TCS_ADDR_CMP3_HI 8'h1C
`define TCS_ADDR_CMP3_LO 8'h1D
`define TCS_ADDR_CAP2_HI 8'h1E
`define TCS_ADDR_CAP2_LO 8'h1F
// reset values and the counter wrap value
`define TCS_PIN_CTRL_RST 8'h20
`define TCS_IRQ_EN_RST 6'h00
`define TCS_CMP_RST 16'hFFFF
`define TCS_CNT_ALL_ONES 16'hFFFF
// flag bit indices inside the status byte
`define TCS_FLAG_WRAP 2
`define TCS_FLAG_M1 3
`define TCS_FLAG_M2 4
`define TCS_FLAG_M3 5
`define TCS_FLAG_C1 6
`define TCS_FLAG_C2 7
`endif

// ==== hw/tcs_pkg.sv ====
package tcs_pkg;
  typedef enum logic [1:0] {
    TCS_IDLE,
    TCS_ACK
  } tcs_bus_state_t;
endpackage

// ==== hw/tcs_edge_detect.sv ====
`timescale 1ns/1ps
`include "tcs_consts.svh"
module tcs_edge_detect
  import tcs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic pin_i,
  input wire logic rising_sel_i,
  output logic edge_o
);
  logic prev;
  wire rise = pin_i & ~prev;
  wire fall = ~pin_i & prev;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      prev <= 1'b0;
      edge_o <= 1'b0;
    end else begin
      prev <= pin_i;
      edge_o <= rising_sel_i ? rise : fall;
    end
  end
endmodule

// ==== hw/tcs_flag.sv ====
`timescale 1ns/1ps
module tcs_flag
  import tcs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic set_i,
  input wire logic arm_i,
  input wire logic clear_i,
  output logic flag_o
);
  // arm latched by a status read with flag set; set wins over clear
  logic armed;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      flag_o <= 1'b0;
      armed <= 1'b0;
    end else begin
      if (set_i)
        flag_o <= 1'b1;
      else if (clear_i && armed)
        flag_o <= 1'b0;
      if (clear_i || !flag_o)
        armed <= 1'b0;
      else if (arm_i && flag_o)
        armed <= 1'b1;
    end
  end
endmodule

// ==== hw/tcs_timer_control_status_bank.sv ====
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ps
`include "tcs_consts.svh"
// Overview of operation
// - match one drives level on port two bit one
// - match two drives level on port one bit one
// - match three drives level on port one bit two
// - reset clears levels and level latches
// - capture one on selected edge, default falling
// - capture two on selected edge, default falling
// - drive select one resets to one, muxes pin
// - drive selects two, three reset zero, mux pins
// - enable register low bits read one normally
// - any enabled flag raises shared interrupt
// - test and half bits reset one, mode0 writable
// - test mode advances only selected counter half
// - test mode makes low byte latch transparent
// - status register read only, low bits one
// - wrap flag set all ones, cleared by status/high
// - match one cleared by status read then write
// - match two, three cleared by status then write
// - capture one cleared by status then high read
// - capture two cleared by status then high read
// - combined register mirrors same storage bits
// - every match clocks level regardless of flag
module tcs_timer_control_status_bank
  import tcs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [7:0] avs_writedata_i,
  output logic [7:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic mode_zero_i,
  input wire logic port_two_bit_zero_i,
  input wire logic port_one_bit_zero_i,
  input wire logic port_two_ddr_bit_one_i,
  input wire logic port_one_ddr_bit_one_i,
  input wire logic port_one_ddr_bit_two_i,
  input wire logic port_two_data_bit_one_i,
  input wire logic port_one_data_bit_one_i,
  input wire logic port_one_data_bit_two_i,
  output logic port_two_bit_one_o,
  output logic port_two_bit_one_oe_o,
  output logic port_one_bit_one_o,
  output logic port_one_bit_one_oe_o,
  output logic port_one_bit_two_o,
  output logic port_one_bit_two_oe_o,
  output logic shared_level2_interrupt_o
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  tcs_bus_state_t state;
  logic [7:0] pin_ctrl;
  logic [5:0] irq_en;
  logic test_n;
  logic half_sel;
  logic [2:0] level_latch;
  logic [15:0] counter;
  logic [7:0] lo_latch;
  logic [15:0] cmp1;
  logic [15:0] cmp2;
  logic [15:0] cmp3;
  logic [15:0] cap1;
  logic [15:0] cap2;
  logic [7:0] cap1_lo_latch;
  logic [7:0] cap2_lo_latch;
  logic [5:0] flags;
  logic [7:0] next_readdata;

  wire compare_level_1 = pin_ctrl[0];
  wire compare_level_2 = pin_ctrl[1];
  wire compare_level_3 = pin_ctrl[2];
  wire capture_edge_sel_1 = pin_ctrl[3];
  wire capture_edge_sel_2 = pin_ctrl[4];
  wire pin_drive_sel_1 = pin_ctrl[5];
  wire pin_drive_sel_2 = pin_ctrl[6];
  wire pin_drive_sel_3 = pin_ctrl[7];
  wire wrap_irq_en = irq_en[0];
  wire match_irq_en_1 = irq_en[1];
  wire match_irq_en_2 = irq_en[2];
  wire match_irq_en_3 = irq_en[3];
  wire capture_irq_en_1 = irq_en[4];
  wire capture_irq_en_2 = irq_en[5];
  wire wrap_flag = flags[0];
  wire match_flag_1 = flags[1];
  wire match_flag_2 = flags[2];
  wire match_flag_3 = flags[3];
  wire capture_flag_1 = flags[4];
  wire capture_flag_2 = flags[5];

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire bus_take = (state == TCS_IDLE) & (avs_read_i | avs_write_i);
  wire rd = bus_take & avs_read_i;
  wire wr = bus_take & avs_write_i;
  wire [7:0] a = avs_address_i;
  wire rd_comb = rd & (a == `TCS_ADDR_COMBINED);
  wire rd_stat = rd & (a == `TCS_ADDR_STATUS);
  wire rd_cnt_hi = rd & (a == `TCS_ADDR_CNT_HI);
  wire rd_cap1_hi = rd & (a == `TCS_ADDR_CAP1_HI);
  wire rd_cap2_hi = rd & (a == `TCS_ADDR_CAP2_HI);
  wire wr_comb = wr & (a == `TCS_ADDR_COMBINED);
  wire wr_pin = wr & (a == `TCS_ADDR_PIN_CTRL);
  wire wr_en = wr & (a == `TCS_ADDR_IRQ_EN);
  wire wr_c1h = wr & (a == `TCS_ADDR_CMP1_HI);
  wire wr_c1l = wr & (a == `TCS_ADDR_CMP1_LO);
  wire wr_c2h = wr & (a == `TCS_ADDR_CMP2_HI);
  wire wr_c2l = wr & (a == `TCS_ADDR_CMP2_LO);
  wire wr_c3h = wr & (a == `TCS_ADDR_CMP3_HI);
  wire wr_c3l = wr & (a == `TCS_ADDR_CMP3_LO);
  wire [7:0] d = avs_writedata_i;

  // ----------------------------------------------------------------
  // counter and matches
  // ----------------------------------------------------------------
  wire test_active = ~test_n;
  wire [7:0] cnt_hi_inc = counter[15:8] + 8'h01;
  wire [7:0] cnt_lo_inc = counter[7:0] + 8'h01;
  wire [15:0] cnt_inc = counter + 16'h0001;
  wire [15:0] next_counter = !test_active ? cnt_inc :
    (half_sel ? {counter[15:8], cnt_lo_inc} :
                {cnt_hi_inc, counter[7:0]});
  wire match1 = (counter == cmp1);
  wire match2 = (counter == cmp2);
  wire match3 = (counter == cmp3);
  wire wrap_now = (counter == `TCS_CNT_ALL_ONES);
  logic cap1_ev;
  logic cap2_ev;

  // ----------------------------------------------------------------
  // capture edges and flags
  // ----------------------------------------------------------------
  tcs_edge_detect u_edge1 (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(port_two_bit_zero_i),
    .rising_sel_i(capture_edge_sel_1),
    .edge_o(cap1_ev)
  );
  tcs_edge_detect u_edge2 (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(port_one_bit_zero_i),
    .rising_sel_i(capture_edge_sel_2),
    .edge_o(cap2_ev)
  );

  wire arm_both = rd_comb | rd_stat;
  wire [5:0] flag_set = {cap2_ev, cap1_ev, match3, match2, match1,
                         wrap_now};
  // overflow, match1 and capture1 arm from either status address
  wire [5:0] flag_arm = {rd_stat, arm_both, rd_stat, rd_stat, arm_both,
                         arm_both};
  wire [5:0] flag_clr = {rd_cap2_hi, rd_cap1_hi, wr_c3h | wr_c3l,
                         wr_c2h | wr_c2l, wr_c1h | wr_c1l, rd_cnt_hi};

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_flag
      tcs_flag u_flag (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .set_i(flag_set[gi]),
        .arm_i(flag_arm[gi]),
        .clear_i(flag_clr[gi]),
        .flag_o(flags[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  wire [7:0] status_byte = {capture_flag_2, capture_flag_1,
    match_flag_3, match_flag_2, match_flag_1, wrap_flag,
    2'b11};
  wire [1:0] en_low = test_active ? {test_n, half_sel} :
                                     2'b11;
  wire [7:0] en_byte = {capture_irq_en_2, capture_irq_en_1,
    match_irq_en_3, match_irq_en_2, match_irq_en_1, wrap_irq_en,
    en_low};
  wire [7:0] comb_byte = {capture_flag_1, match_flag_1, wrap_flag,
    capture_irq_en_1, match_irq_en_1, wrap_irq_en,
    capture_edge_sel_1, compare_level_1};
  wire [7:0] cnt_lo_view = test_active ? counter[7:0] :
                                          lo_latch;

  always_comb begin
    unique case (a)
      `TCS_ADDR_COMBINED: next_readdata = comb_byte;
      `TCS_ADDR_CNT_HI: next_readdata = counter[15:8];
      `TCS_ADDR_CNT_LO: next_readdata = cnt_lo_view;
      `TCS_ADDR_CMP1_HI: next_readdata = cmp1[15:8];
      `TCS_ADDR_CMP1_LO: next_readdata = cmp1[7:0];
      `TCS_ADDR_CAP1_HI: next_readdata = cap1[15:8];
      `TCS_ADDR_CAP1_LO: next_readdata = cap1_lo_latch;
      `TCS_ADDR_PIN_CTRL: next_readdata = pin_ctrl;
      `TCS_ADDR_IRQ_EN: next_readdata = en_byte;
      `TCS_ADDR_STATUS: next_readdata = status_byte;
      `TCS_ADDR_CMP2_HI: next_readdata = cmp2[15:8];
      `TCS_ADDR_CMP2_LO: next_readdata = cmp2[7:0];
      `TCS_ADDR_CMP3_HI: next_readdata = cmp3[15:8];
      `TCS_ADDR_CMP3_LO: next_readdata = cmp3[7:0];
      `TCS_ADDR_CAP2_HI: next_readdata = cap2[15:8];
      `TCS_ADDR_CAP2_LO: next_readdata = cap2_lo_latch;
      default: next_readdata = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state <= TCS_IDLE;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 8'h00;
    end else begin
      unique case (state)
        TCS_IDLE: begin
          if (bus_take) begin
            state <= TCS_ACK;
            avs_waitrequest_o <= 1'b0;
            avs_readdata_o <= avs_read_i ? next_readdata : 8'h00;
          end
        end
        TCS_ACK: begin
          state <= TCS_IDLE;
          avs_waitrequest_o <= 1'b1;
        end
        default: begin
          state <= TCS_IDLE;
          avs_waitrequest_o <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pin_ctrl <= `TCS_PIN_CTRL_RST;
      irq_en <= `TCS_IRQ_EN_RST;
      test_n <= 1'b1;
      half_sel <= 1'b1;
    end else begin
      if (wr_pin)
        pin_ctrl <= d;
      else if (wr_comb) begin
        pin_ctrl[0] <= d[0];
        pin_ctrl[3] <= d[1];
      end
      if (wr_en) begin
        irq_en <= d[7:2];
        if (mode_zero_i) begin
          test_n <= d[1];
          half_sel <= d[0];
        end else begin
          test_n <= 1'b1;
          half_sel <= 1'b1;
        end
      end else if (wr_comb) begin
        irq_en[0] <= d[2];
        irq_en[1] <= d[3];
        irq_en[4] <= d[4];
      end
    end
  end

  // ----------------------------------------------------------------
  // counter, compares, captures
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      counter <= 16'h0000;
      lo_latch <= 8'h00;
      cmp1 <= `TCS_CMP_RST;
      cmp2 <= `TCS_CMP_RST;
      cmp3 <= `TCS_CMP_RST;
      cap1 <= 16'h0000;
      cap2 <= 16'h0000;
      cap1_lo_latch <= 8'h00;
      cap2_lo_latch <= 8'h00;
      level_latch <= 3'b000;
    end else begin
      counter <= next_counter;
      if (rd_cnt_hi)
        lo_latch <= counter[7:0];
      if (wr_c1h) cmp1[15:8] <= d;
      if (wr_c1l) cmp1[7:0] <= d;
      if (wr_c2h) cmp2[15:8] <= d;
      if (wr_c2l) cmp2[7:0] <= d;
      if (wr_c3h) cmp3[15:8] <= d;
      if (wr_c3l) cmp3[7:0] <= d;
      if (cap1_ev) cap1 <= counter;
      if (cap2_ev) cap2 <= counter;
      if (rd_cap1_hi) cap1_lo_latch <= cap1[7:0];
      if (rd_cap2_hi) cap2_lo_latch <= cap2[7:0];
      if (match1) level_latch[0] <= compare_level_1;
      if (match2) level_latch[1] <= compare_level_2;
      if (match3) level_latch[2] <= compare_level_3;
    end
  end

  // ----------------------------------------------------------------
  // pins and interrupt
  // ----------------------------------------------------------------
  wire irq_any = |(flags & irq_en);
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      port_two_bit_one_o <= 1'b0;
      port_one_bit_one_o <= 1'b0;
      port_one_bit_two_o <= 1'b0;
      port_two_bit_one_oe_o <= 1'b0;
      port_one_bit_one_oe_o <= 1'b0;
      port_one_bit_two_oe_o <= 1'b0;
      shared_level2_interrupt_o <= 1'b0;
    end else begin
      port_two_bit_one_o <= pin_drive_sel_1 ? level_latch[0] :
                            port_two_data_bit_one_i;
      port_one_bit_one_o <= pin_drive_sel_2 ? level_latch[1] :
                            port_one_data_bit_one_i;
      port_one_bit_two_o <= pin_drive_sel_3 ? level_latch[2] :
                            port_one_data_bit_two_i;
      port_two_bit_one_oe_o <= port_two_ddr_bit_one_i;
      port_one_bit_one_oe_o <= port_one_ddr_bit_one_i;
      port_one_bit_two_oe_o <= port_one_ddr_bit_two_i;
      shared_level2_interrupt_o <= irq_any;
    end
  end
endmodule

// ==== tb/tcs_bank_asserts.sv ====
`timescale 1ns/1ps
`include "tcs_consts.svh"
module tcs_bank_asserts (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [7:0] avs_writedata_i,
  input wire logic [7:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic mode_zero_i,
  input wire logic port_two_ddr_bit_one_i,
  input wire logic port_one_ddr_bit_one_i,
  input wire logic port_one_ddr_bit_two_i,
  input wire logic port_two_bit_one_o,
  input wire logic port_two_bit_one_oe_o,
  input wire logic port_one_bit_one_o,
  input wire logic port_one_bit_one_oe_o,
  input wire logic port_one_bit_two_o,
  input wire logic port_one_bit_two_oe_o,
  input wire logic shared_level2_interrupt_o
);
  // ----
  // helper state
  // ----
  logic en_seen;
  logic test_on;
  wire wr_ack = avs_write_i && !avs_waitrequest_o;
  wire rd_ack = avs_read_i && !avs_waitrequest_o;
  wire at_en = avs_address_i == `TCS_ADDR_IRQ_EN;
  wire en_wr = wr_ack && (at_en || avs_address_i == `TCS_ADDR_COMBINED);
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      en_seen <= 1'b0;
      test_on <= 1'b0;
    end else begin
      if (en_wr)
        en_seen <= 1'b1;
      if (wr_ack && at_en && mode_zero_i)
        test_on <= !avs_writedata_i[1];
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_oe(logic oe, logic ddr);
    $past(rst_n_i) |-> oe == $past(ddr);
  endproperty
  property p_ones(logic [7:0] a, logic ok);
    rd_ack && avs_address_i == a && ok |-> avs_readdata_o[1:0] == 2'b11;
  endproperty
  AST_ACK_NEXT: assert property ((avs_read_i || avs_write_i) &&
    avs_waitrequest_o |=> !avs_waitrequest_o) else $error("no answer");
  AST_ACK_ONE: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("answer too long");
  AST_ACK_CAUSE: assert property ($fell(avs_waitrequest_o) |->
    $past(avs_read_i || avs_write_i)) else $error("answer unasked");
  AST_OE_P21: assert property (p_oe(port_two_bit_one_oe_o,
    port_two_ddr_bit_one_i)) else $error("p21 enable wrong");
  AST_OE_P11: assert property (p_oe(port_one_bit_one_oe_o,
    port_one_ddr_bit_one_i)) else $error("p11 enable wrong");
  AST_OE_P12: assert property (p_oe(port_one_bit_two_oe_o,
    port_one_ddr_bit_two_i)) else $error("p12 enable wrong");
  AST_RST_PINS: assert property (disable iff (1'b0) !rst_n_i |=>
    !port_two_bit_one_o && !port_one_bit_one_o && !port_one_bit_two_o)
    else $error("pins not cleared by reset");
  AST_RST_IRQ: assert property (disable iff (1'b0) !rst_n_i |=>
    !shared_level2_interrupt_o) else $error("irq in reset");
  AST_IRQ_EN: assert property (shared_level2_interrupt_o |-> en_seen)
    else $error("irq without enable");
  AST_STATUS_ONES: assert property (p_ones(`TCS_ADDR_STATUS, 1'b1))
    else $error("status low bits");
  AST_IRQEN_ONES: assert property (p_ones(`TCS_ADDR_IRQ_EN, !test_on))
    else $error("enable low bits");
  cover property ($rose(shared_level2_interrupt_o));
  cover property (rd_ack && avs_address_i == `TCS_ADDR_STATUS);
  cover property (wr_ack && avs_address_i == `TCS_ADDR_PIN_CTRL);
endmodule
bind tcs_timer_control_status_bank tcs_bank_asserts u_chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .mode_zero_i(mode_zero_i),
  .port_two_ddr_bit_one_i(port_two_ddr_bit_one_i),
  .port_one_ddr_bit_one_i(port_one_ddr_bit_one_i),
  .port_one_ddr_bit_two_i(port_one_ddr_bit_two_i),
  .port_two_bit_one_o(port_two_bit_one_o),
  .port_two_bit_one_oe_o(port_two_bit_one_oe_o),
  .port_one_bit_one_o(port_one_bit_one_o),
  .port_one_bit_one_oe_o(port_one_bit_one_oe_o),
  .port_one_bit_two_o(port_one_bit_two_o),
  .port_one_bit_two_oe_o(port_one_bit_two_oe_o),
  .shared_level2_interrupt_o(shared_level2_interrupt_o));

// ==== tb/tcs_cpu_model.sv ====
`timescale 1ns/1ps
module tcs_cpu_model (
  input wire logic clk_i,
  input wire logic [7:0] readdata_i,
  input wire logic waitrequest_i,
  output logic [7:0] address_o,
  output logic read_o,
  output logic write_o,
  output logic [7:0] writedata_o
);
  initial begin
    address_o = 8'h00;
    read_o = 1'b0;
    write_o = 1'b0;
    writedata_o = 8'h00;
  end
  // ----
  // one transfer, entered just after a rising edge
  // ----
  task automatic xfer(input logic wr, input logic [7:0] a,
    input logic [7:0] d, output logic [7:0] q, output logic ok);
    address_o <= a;
    writedata_o <= d;
    read_o <= !wr;
    write_o <= wr;
    ok = 1'b0;
    q = 8'h00;
    // sample the answer at the rising edge, before that edge's updates
    for (int n = 0; n < 40 && !ok; n++) begin
      @(posedge clk_i);
      ok = (waitrequest_i === 1'b0);
    end
    q = readdata_i;
    // released lines do not keep the last value
    address_o <= ~a;
    writedata_o <= ~d;
    read_o <= 1'b0;
    write_o <= 1'b0;
    @(posedge clk_i);
  endtask
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`include "tcs_consts.svh"
module testbench;
  logic clk_i;
  logic rst_n_i;
  logic [7:0] addr, wdata, rdata, pc, en, st;
  logic rd_r, wr_r, waitreq, mode_zero, irq;
  logic [1:0] cap_pin;
  logic [2:0] ddr, dat, pin, oe, lat;
  int error_cnt, n_tests, seed;
  tcs_timer_control_status_bank dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(addr),
    .avs_read_i(rd_r), .avs_write_i(wr_r), .avs_writedata_i(wdata),
    .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
    .mode_zero_i(mode_zero), .port_two_bit_zero_i(cap_pin[0]),
    .port_one_bit_zero_i(cap_pin[1]), .port_two_ddr_bit_one_i(ddr[0]),
    .port_one_ddr_bit_one_i(ddr[1]), .port_one_ddr_bit_two_i(ddr[2]),
    .port_two_data_bit_one_i(dat[0]), .port_one_data_bit_one_i(dat[1]),
    .port_one_data_bit_two_i(dat[2]), .port_two_bit_one_o(pin[0]),
    .port_two_bit_one_oe_o(oe[0]), .port_one_bit_one_o(pin[1]),
    .port_one_bit_one_oe_o(oe[1]), .port_one_bit_two_o(pin[2]),
    .port_one_bit_two_oe_o(oe[2]), .shared_level2_interrupt_o(irq));
  tcs_cpu_model cpu (
    .clk_i(clk_i), .readdata_i(rdata), .waitrequest_i(waitreq),
    .address_o(addr), .read_o(rd_r), .write_o(wr_r), .writedata_o(wdata));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // ----
  // shared tasks
  // ----
  task automatic print_verdict;
    $display("tests %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
    input string m);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [7:0] d, output logic [7:0] q);
    logic ok;
    cpu.xfer(w, a, d, q, ok);
    if (!ok) begin
      error_cnt++;
      $display("BAD %0t no answer at %h", $time, a);
      print_verdict();
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q, exp, "read");
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic chk_regs;
    rc(`TCS_ADDR_PIN_CTRL, pc);
    rc(`TCS_ADDR_IRQ_EN, {en[7:2], 2'b11});
    rc(`TCS_ADDR_STATUS, {st[7:2], 2'b11});
    rc(`TCS_ADDR_COMBINED, {st[6], st[3:2], en[6], en[3:2], pc[3], pc[0]});
    @(negedge clk_i);
    chk({7'h00, irq}, {7'h00, |(st[7:2] & en[7:2])}, "irq");
    @(posedge clk_i);
  endtask
  task automatic chk_pins;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    chk({2'h0, oe, pin}, {2'h0, ddr, pc[7] ? lat[2] : dat[2],
      pc[6] ? lat[1] : dat[1], pc[5] ? lat[0] : dat[0]}, "pins");
    @(posedge clk_i);
  endtask
  task automatic do_reset;
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    pc = `TCS_PIN_CTRL_RST;
    en = 8'h00;
    st = 8'h00;
    lat = 3'h0;
    @(posedge clk_i);
    chk_regs();
    chk_pins();
    $display("test reset done");
  endtask
  // ----
  // scenarios
  // ----
  task automatic match_run(input int c);
    logic [7:0] hi, lo, r, ah;
    logic [15:0] t;
    ah = c == 0 ? `TCS_ADDR_CMP1_HI : c == 1 ? `TCS_ADDR_CMP2_HI :
      `TCS_ADDR_CMP3_HI;
    pc = 8'($random(seed));
    wr(`TCS_ADDR_PIN_CTRL, pc);
    r = 8'($random(seed)) | (8'h08 << c);
    wr(`TCS_ADDR_IRQ_EN, r);
    en = r & 8'hFC;
    {ddr, dat} <= 6'($random(seed));
    bus(1'b0, `TCS_ADDR_CNT_HI, 8'h00, hi);
    bus(1'b0, `TCS_ADDR_CNT_LO, 8'h00, lo);
    t = {hi, lo} + 16'h0050;
    // low byte first so a stale high byte cannot match early
    wr(ah + 8'h01, t[7:0]);
    wr(ah, t[15:8]);
    for (int n = 0; n < 200 && irq !== 1'b1; n++) @(posedge clk_i);
    if (irq !== 1'b1) begin
      error_cnt++;
      $display("BAD %0t no match event", $time);
      print_verdict();
    end
    lat[c] = pc[c];
    st[3 + c] = 1'b1;
    chk_pins();
    chk_regs();
    wr(ah + 8'h01, t[7:0]);
    st[3 + c] = 1'b0;
    chk_regs();
    $display("test match %0d done", c);
  endtask
  task automatic cap_run(input int c, input logic s);
    logic [7:0] q;
    pc[3 + c] = s;
    wr(`TCS_ADDR_PIN_CTRL, pc);
    cap_pin[c] <= !s;
    repeat (4) @(posedge clk_i);
    chk_regs();
    cap_pin[c] <= s;
    repeat (4) @(posedge clk_i);
    st[6 + c] = 1'b1;
    chk_regs();
    bus(1'b0, c == 0 ? `TCS_ADDR_CAP1_HI : `TCS_ADDR_CAP2_HI, 8'h00, q);
    st[6 + c] = 1'b0;
    chk_regs();
    $display("test capture %0d edge %0d done", c, s);
  endtask
  initial begin
    seed = 72;
    error_cnt = 0;
    n_tests = 0;
    mode_zero <= 1'b0;
    cap_pin <= 2'b00;
    ddr <= 3'h0;
    dat <= 3'h0;
    do_reset();
    wr(`TCS_ADDR_STATUS, 8'hFF);
    rc(8'h00, 8'h00);
    chk_regs();
    for (int k = 0; k < 6; k++) match_run(k % 3);
    for (int k = 0; k < 4; k++) cap_run(k / 2, k[0]);
    do_reset();
    print_verdict();
  end
endmodule
